// ==== clock_tree_consts.svh ====
`ifndef CLOCK_TREE_CONSTS_SVH
`define CLOCK_TREE_CONSTS_SVH

`define NUM_SOURCES 7
`define NUM_DIG_DIV 8
`define NUM_SYNC 15
`define DIV_W 16
`define FAST_WHEEL_W 5
`define CENTRAL_W 16
`define SEC_CNT_W 15
`define THIRD_CNT_W 2

// Watch crystal edges per second, minus one
`define SEC_CNT_LAST 15'h7fff
// Divide-by-3 counts 0, 1, 2
`define THIRD_CNT_LAST 2'h2
`define COUNT_RESET 16'h0000

`endif

// ==== clock_tree_pkg.sv ====
`include "clock_tree_consts.svh"

package clock_tree_pkg;

    typedef enum logic [2:0] {
        SRC_MAIN_OSC = 3'b000,
        SRC_PLL = 3'b001,
        SRC_FAST_XTAL = 3'b010,
        SRC_WATCH_XTAL = 3'b011,
        SRC_LOW_POWER = 3'b100,
        SRC_ICONN = 3'b101,
        SRC_USB = 3'b110
    } source_sel_type;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } sync_state_type;

    typedef struct packed {
        logic [`DIV_W-1:0] count;
        logic tick;
        logic level;
    } div_state_type;

    typedef struct packed {
        logic master_tick;
        logic [`THIRD_CNT_W-1:0] third_cnt;
        logic third_tick;
        logic [`FAST_WHEEL_W-1:0] fast_cnt;
        logic fast_irq;
        logic [`CENTRAL_W-1:0] central_cnt;
        logic central_irq;
        logic wake;
        logic [`SEC_CNT_W-1:0] sec_cnt;
        logic second_irq;
        logic sleep_tick;
        logic watch_mode;
    } top_state_type;

endpackage

// ==== edge_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module edge_sync
    import clock_tree_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic async_in,
    output logic pulse
);

    sync_state_type sync_ff;
    sync_state_type nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_sync = sync_ff;
        nxt_sync.s1 = async_in;
        nxt_sync.s2 = sync_ff.s1;
        nxt_sync.s3 = sync_ff.s2;
        nxt_sync.pulse = sync_ff.s2 & ~sync_ff.s3;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync_ff <= '0;
        end else begin
            sync_ff <= nxt_sync;
        end
    end

    assign pulse = sync_ff.pulse;

    sequence rise_seen;
        !sync_ff.s3 && sync_ff.s2;
    endsequence

    a_edge_pulse: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rise_seen |=> pulse ##1 !pulse)
    else $error("Source edge did not give one pulse");

endmodule // edge_sync

`default_nettype wire

// ==== clk_divider16.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_consts.svh"

module clk_divider16
    import clock_tree_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic en,
    input wire logic [`DIV_W-1:0] divisor,
    output logic tick,
    output logic level
);

    div_state_type div_ff;
    div_state_type nxt_div;

    always_comb begin
        nxt_div = div_ff;
        nxt_div.tick = 1'b0;
        if (en) begin
            if (div_ff.count == `COUNT_RESET) begin
                nxt_div.count = divisor;
                nxt_div.tick = 1'b1;
                // Toggle per terminal count gives an even duty cycle
                nxt_div.level = ~div_ff.level;
            end else begin
                nxt_div.count = div_ff.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            div_ff <= '0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    assign tick = div_ff.tick;
    assign level = div_ff.level;

    a_div_reload: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        en && div_ff.count == `COUNT_RESET
        |=> tick && div_ff.count == $past(divisor) && level != $past(level))
    else $error("Divider missed reload at terminal count");

    a_div_step: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        en && div_ff.count != `COUNT_RESET
        |=> !tick && div_ff.count == $past(div_ff.count) - 16'h0001)
    else $error("Divider failed to count down");

endmodule // clk_divider16

`default_nettype wire

// ==== clock_timewheel_and_dividers.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_consts.svh"

module clock_timewheel_and_dividers
    import clock_tree_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`NUM_SOURCES-1:0] clock_sources,
    input wire logic [`NUM_DIG_DIV-1:0] routed_clocks,
    input wire source_sel_type master_sel,
    input wire logic [1:0] ext_osc_div_en,
    input wire logic [`DIV_W-1:0] ext_osc_divisor,
    input wire logic [`DIV_W-1:0] bus_divisor,
    input wire logic [`DIV_W-1:0] cpu_divisor,
    input wire logic [`NUM_DIG_DIV-1:0][`DIV_W-1:0] dig_divisors,
    input wire logic [`NUM_DIG_DIV-1:0] dig_use_routed,
    input wire logic [`FAST_WHEEL_W-1:0] fast_wheel_tc,
    input wire logic fast_wheel_irq_en,
    input wire logic [`CENTRAL_W-1:0] central_period,
    input wire logic central_irq_en,
    input wire logic central_reset,
    input wire logic wake_en,
    input wire logic sleep_active,
    input wire logic watch_low_power_mode,
    output logic master_tick,
    output logic bus_tick,
    output logic cpu_tick,
    output logic [`NUM_DIG_DIV-1:0] dig_tick,
    output logic [`NUM_DIG_DIV-1:0] dig_clk,
    output logic [1:0] ext_osc_div_clk,
    output logic third_rate_tick,
    output logic [`FAST_WHEEL_W-1:0] fast_wheel_count,
    output logic fast_wheel_irq,
    output logic central_irq,
    output logic wake_event,
    output logic second_irq,
    output logic sleep_timer_tick,
    output logic watch_power_mode
);

    top_state_type st_ff;
    top_state_type nxt_st;
    logic [`NUM_SYNC-1:0] edge_pulse;
    logic [`NUM_SOURCES-1:0] src_pulse;
    logic [`NUM_DIG_DIV-1:0] routed_pulse;
    logic [1:0] ext_div_tick;
    logic [`NUM_DIG_DIV-1:0] dig_en;
    logic lp_pulse;
    logic watch_pulse;
    logic fast_pulse;
    logic sel_pulse;
    logic [`NUM_SYNC-1:0] sync_in;

    // One vector keeps every synchroniser index in range
    assign sync_in = {routed_clocks, clock_sources};

    // routed clocks share the same front end
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_SYNC; gi = gi + 1) begin : g_sync
            edge_sync u_sync (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .async_in(sync_in[gi]),
                .pulse(edge_pulse[gi])
            );
        end
    endgenerate

    assign src_pulse = edge_pulse[`NUM_SOURCES-1:0];
    assign routed_pulse = edge_pulse[`NUM_SYNC-1:`NUM_SOURCES];
    assign lp_pulse = src_pulse[SRC_LOW_POWER];
    assign watch_pulse = src_pulse[SRC_WATCH_XTAL];
    assign fast_pulse = src_pulse[SRC_FAST_XTAL];

    clk_divider16 u_fast_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(fast_pulse),
        .divisor(ext_osc_divisor),
        .tick(ext_div_tick[0]),
        .level(ext_osc_div_clk[0])
    );

    clk_divider16 u_watch_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(watch_pulse),
        .divisor(ext_osc_divisor),
        .tick(ext_div_tick[1]),
        .level(ext_osc_div_clk[1])
    );

    always_comb begin
        sel_pulse = src_pulse[master_sel];
        if (master_sel == SRC_FAST_XTAL && ext_osc_div_en[0]) begin
            sel_pulse = ext_div_tick[0];
        end
        if (master_sel == SRC_WATCH_XTAL && ext_osc_div_en[1]) begin
            sel_pulse = ext_div_tick[1];
        end
    end

    clk_divider16 u_bus_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(st_ff.master_tick),
        .divisor(bus_divisor),
        .tick(bus_tick),
        .level()
    );

    // CPU divider fed by bus clock
    clk_divider16 u_cpu_div (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(bus_tick),
        .divisor(cpu_divisor),
        .tick(cpu_tick),
        .level()
    );

    generate
        for (gi = 0; gi < `NUM_DIG_DIV; gi = gi + 1) begin : g_dig
            assign dig_en[gi] = dig_use_routed[gi] ? routed_pulse[gi]
                                                   : st_ff.master_tick;
            clk_divider16 u_dig_div (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .en(dig_en[gi]),
                .divisor(dig_divisors[gi]),
                .tick(dig_tick[gi]),
                .level(dig_clk[gi])
            );

            a_routed_only: assert property (
                @(posedge sys_clk) disable iff (!rstn)
                dig_use_routed[gi] && !routed_pulse[gi] |=> !dig_tick[gi])
            else $error("Routed divider ticked without routed edge");
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        nxt_st.master_tick = sel_pulse;
        nxt_st.third_tick = 1'b0;
        nxt_st.fast_irq = 1'b0;
        nxt_st.central_irq = 1'b0;
        nxt_st.wake = 1'b0;
        nxt_st.second_irq = 1'b0;
        nxt_st.watch_mode = watch_low_power_mode;
        // sleep timer sees every watch edge
        nxt_st.sleep_tick = watch_pulse;

        if (lp_pulse) begin
            if (st_ff.third_cnt == `THIRD_CNT_LAST) begin
                nxt_st.third_cnt = '0;
                nxt_st.third_tick = 1'b1;
            end else begin
                nxt_st.third_cnt = st_ff.third_cnt + 2'h1;
            end
            if (st_ff.fast_cnt == fast_wheel_tc) begin
                nxt_st.fast_cnt = '0;
                nxt_st.fast_irq = fast_wheel_irq_en;
            end else begin
                nxt_st.fast_cnt = st_ff.fast_cnt + 5'h01;
            end
            if (st_ff.central_cnt == central_period) begin
                nxt_st.central_cnt = '0;
                nxt_st.central_irq = central_irq_en;
                nxt_st.wake = wake_en & sleep_active;
            end else begin
                nxt_st.central_cnt = st_ff.central_cnt + 16'h0001;
            end
        end

        if (central_reset) begin
            nxt_st.central_cnt = '0;
        end

        if (watch_pulse) begin
            if (st_ff.sec_cnt == `SEC_CNT_LAST) begin
                nxt_st.sec_cnt = '0;
                nxt_st.second_irq = 1'b1;
            end else begin
                nxt_st.sec_cnt = st_ff.sec_cnt + 15'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign master_tick = st_ff.master_tick;
    assign third_rate_tick = st_ff.third_tick;
    assign fast_wheel_count = st_ff.fast_cnt;
    assign fast_wheel_irq = st_ff.fast_irq;
    assign central_irq = st_ff.central_irq;
    assign wake_event = st_ff.wake;
    assign second_irq = st_ff.second_irq;
    assign sleep_timer_tick = st_ff.sleep_tick;
    assign watch_power_mode = st_ff.watch_mode;

    sequence fast_at_tc;
        lp_pulse && st_ff.fast_cnt == fast_wheel_tc;
    endsequence

    a_fast_step: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        lp_pulse && st_ff.fast_cnt != fast_wheel_tc
        |=> st_ff.fast_cnt == $past(st_ff.fast_cnt) + 5'h01)
    else $error("Fast timewheel did not step");

    a_fast_wrap: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        fast_at_tc |=> st_ff.fast_cnt == 5'h00)
    else $error("Fast timewheel did not wrap");

    a_fast_irq: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        fast_at_tc ##0 fast_wheel_irq_en |=> fast_wheel_irq ##1 !fast_wheel_irq)
    else $error("Fast timewheel interrupt missing");

    a_central_wake: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        lp_pulse && st_ff.central_cnt == central_period && !central_reset
        |=> central_irq == $past(central_irq_en)
            && wake_event == $past(wake_en && sleep_active))
    else $error("Central timewheel event wrong");

    a_central_reset: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        central_reset |=> st_ff.central_cnt == 16'h0000)
    else $error("Central timewheel reset ignored");

    a_master_lp: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        master_sel == SRC_LOW_POWER && lp_pulse |=> master_tick)
    else $error("Low-power master tick missing");

    a_third_rate: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        lp_pulse && st_ff.third_cnt == `THIRD_CNT_LAST
        |=> third_rate_tick && st_ff.third_cnt == 2'h0)
    else $error("Divide by three tick missing");

    a_second_irq: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        watch_pulse && st_ff.sec_cnt == `SEC_CNT_LAST |=> second_irq && sleep_timer_tick)
    else $error("One-second interrupt missing");

    a_bus_to_cpu: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        cpu_tick |-> $past(bus_tick))
    else $error("CPU tick without bus tick");

    a_crystal_pick: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        master_sel == SRC_FAST_XTAL && ext_osc_div_en[0] |=> master_tick == $past(ext_div_tick[0]))
    else $error("Divided crystal not used as master");

    a_sleep_feed: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        watch_pulse |=> sleep_timer_tick)
    else $error("Sleep timer missed a watch edge");

    a_watch_mode: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        1'b1 |=> watch_power_mode == $past(watch_low_power_mode))
    else $error("Watch power mode not followed");

endmodule // clock_timewheel_and_dividers

`default_nettype wire

// ==== clock_timewheel_and_dividers_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_consts.svh"

`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    $display("unexpected %s exp %0h got %0h", what, exp, got); n_errors++; end end

module clock_timewheel_and_dividers_tb
    import clock_tree_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [`NUM_SOURCES-1:0] clock_sources = '0;
    logic [`NUM_DIG_DIV-1:0] routed_clocks = '0;
    source_sel_type master_sel = SRC_MAIN_OSC;
    logic [1:0] ext_osc_div_en = 2'h0;
    logic [`DIV_W-1:0] ext_osc_divisor = 16'h0000;
    logic [`DIV_W-1:0] bus_divisor = 16'h0000;
    logic [`DIV_W-1:0] cpu_divisor = 16'h0000;
    logic [`NUM_DIG_DIV-1:0][`DIV_W-1:0] dig_divisors = '0;
    logic [`NUM_DIG_DIV-1:0] dig_use_routed = '0;
    logic [`FAST_WHEEL_W-1:0] fast_wheel_tc = 5'h00;
    logic fast_wheel_irq_en = 1'b0;
    logic [`CENTRAL_W-1:0] central_period = 16'h0000;
    logic central_irq_en = 1'b0;
    logic central_reset = 1'b0;
    logic wake_en = 1'b0;
    logic sleep_active = 1'b0;
    logic watch_low_power_mode = 1'b0;
    logic master_tick, bus_tick, cpu_tick, third_rate_tick, fast_wheel_irq;
    logic central_irq, wake_event, second_irq, sleep_timer_tick, watch_power_mode;
    logic [`NUM_DIG_DIV-1:0] dig_tick;
    logic [`NUM_DIG_DIV-1:0] dig_clk;
    logic [1:0] ext_osc_div_clk;
    logic [`FAST_WHEEL_W-1:0] fast_wheel_count;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int cnt [12];

    clock_timewheel_and_dividers DUT (
        .sys_clk(sys_clk), .rstn(rstn), .clock_sources(clock_sources),
        .routed_clocks(routed_clocks), .master_sel(master_sel),
        .ext_osc_div_en(ext_osc_div_en), .ext_osc_divisor(ext_osc_divisor),
        .bus_divisor(bus_divisor), .cpu_divisor(cpu_divisor),
        .dig_divisors(dig_divisors), .dig_use_routed(dig_use_routed),
        .fast_wheel_tc(fast_wheel_tc), .fast_wheel_irq_en(fast_wheel_irq_en),
        .central_period(central_period), .central_irq_en(central_irq_en),
        .central_reset(central_reset), .wake_en(wake_en), .sleep_active(sleep_active),
        .watch_low_power_mode(watch_low_power_mode), .master_tick(master_tick),
        .bus_tick(bus_tick), .cpu_tick(cpu_tick), .dig_tick(dig_tick), .dig_clk(dig_clk),
        .ext_osc_div_clk(ext_osc_div_clk), .third_rate_tick(third_rate_tick),
        .fast_wheel_count(fast_wheel_count), .fast_wheel_irq(fast_wheel_irq),
        .central_irq(central_irq), .wake_event(wake_event), .second_irq(second_irq),
        .sleep_timer_tick(sleep_timer_tick), .watch_power_mode(watch_power_mode)
    );

    always #12.5 sys_clk = ~sys_clk;

    // Pulse outputs are counted, so latency slips of a cycle do not matter
    always @(posedge sys_clk) begin
        cnt[0] += int'(master_tick === 1'b1);
        cnt[1] += int'(bus_tick === 1'b1);
        cnt[2] += int'(cpu_tick === 1'b1);
        cnt[3] += int'(fast_wheel_irq === 1'b1);
        cnt[4] += int'(third_rate_tick === 1'b1);
        cnt[5] += int'(central_irq === 1'b1);
        cnt[6] += int'(wake_event === 1'b1);
        cnt[7] += int'(sleep_timer_tick === 1'b1);
        cnt[8] += int'(dig_tick[0] === 1'b1);
        cnt[9] += int'(dig_tick[1] === 1'b1);
        cnt[10] += int'(dig_tick[2] === 1'b1);
        cnt[11] += int'(second_irq === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic clear();
        for (int i = 0; i < 12; i++) cnt[i] = 0;
    endtask

    // Edges spaced six cycles apart, well inside the synchroniser limits
    task automatic edges(input logic routed, input int idx, input int n);
        for (int k = 0; k < n; k++) begin
            if (routed) routed_clocks[idx] = 1'b1; else clock_sources[idx] = 1'b1;
            repeat (3) @(negedge sys_clk);
            if (routed) routed_clocks[idx] = 1'b0; else clock_sources[idx] = 1'b0;
            repeat (3) @(negedge sys_clk);
        end
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic t_reset();
        `CHK("outputs after reset", 1'b0, |{master_tick, bus_tick, cpu_tick, dig_tick,
            dig_clk, ext_osc_div_clk, third_rate_tick, fast_wheel_count, fast_wheel_irq,
            central_irq, wake_event, second_irq, sleep_timer_tick, watch_power_mode})
        $display("test reset done");
    endtask

    task automatic t_fast_wheel();
        clear();
        fast_wheel_tc = 5'h03;
        fast_wheel_irq_en = 1'b1;
        edges(1'b0, 4, 9);
        `CHK("fast irq count", 2, cnt[3])
        `CHK("fast count", 5'h01, fast_wheel_count)
        `CHK("third rate ticks", 3, cnt[4])
        fast_wheel_irq_en = 1'b0;
        edges(1'b0, 4, 3);
        `CHK("masked fast irq", 2, cnt[3])
        `CHK("fast wrap", 5'h00, fast_wheel_count)
        $display("test fast wheel done");
    endtask

    task automatic t_central();
        central_period = 16'h0002;
        central_reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        central_reset = 1'b0;
        central_irq_en = 1'b1;
        wake_en = 1'b1;
        sleep_active = 1'b1;
        clear();
        edges(1'b0, 4, 6);
        `CHK("central irq", 2, cnt[5])
        `CHK("wake events", 2, cnt[6])
        sleep_active = 1'b0;
        edges(1'b0, 4, 3);
        `CHK("central irq awake", 3, cnt[5])
        `CHK("no wake awake", 2, cnt[6])
        // Held reset keeps the count at zero, so no period ever completes
        central_reset = 1'b1;
        edges(1'b0, 4, 6);
        `CHK("central held", 3, cnt[5])
        central_reset = 1'b0;
        $display("test central wheel done");
    endtask

    task automatic t_master();
        master_sel = SRC_LOW_POWER;
        bus_divisor = 16'h0002;
        cpu_divisor = 16'h0000;
        dig_divisors[0] = 16'h0000;
        dig_divisors[1] = 16'h0001;
        dig_divisors[7] = 16'h0005;
        clear();
        edges(1'b0, 4, 6);
        `CHK("master ticks", 6, cnt[0])
        `CHK("bus ticks", 2, cnt[1])
        `CHK("cpu ticks", 2, cnt[2])
        `CHK("div0 ticks", 6, cnt[8])
        `CHK("div1 ticks", 3, cnt[9])
        `CHK("div clocks", 8'h82, dig_clk)
        master_sel = SRC_FAST_XTAL;
        ext_osc_div_en = 2'h1;
        clear();
        edges(1'b0, 2, 3);
        `CHK("crystal master", 3, cnt[0])
        `CHK("crystal divided", 1'b1, ext_osc_div_clk[0])
        $display("test master and dividers done");
    endtask

    task automatic t_routed();
        master_sel = SRC_MAIN_OSC;
        dig_use_routed = 8'h04;
        dig_divisors[2] = 16'h0000;
        clear();
        edges(1'b1, 2, 4);
        `CHK("routed div ticks", 4, cnt[10])
        `CHK("other div idle", 0, cnt[8])
        $display("test routed done");
    endtask

    // Full second needs 32768 edges, too long here; only the quiet part is checked
    task automatic t_watch();
        watch_low_power_mode = 1'b1;
        master_sel = SRC_WATCH_XTAL;
        ext_osc_div_en = 2'h2;
        ext_osc_divisor = 16'h0001;
        clear();
        edges(1'b0, 3, 4);
        `CHK("sleep ticks", 4, cnt[7])
        `CHK("no second yet", 0, cnt[11])
        `CHK("power mode", 1'b1, watch_power_mode)
        `CHK("watch divided master", 2, cnt[0])
        edges(1'b0, 3, 1);
        `CHK("watch divided level", 1'b1, ext_osc_div_clk[1])
        `CHK("watch divided master more", 3, cnt[0])
        watch_low_power_mode = 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK("power mode off", 1'b0, watch_power_mode)
        $display("test watch done");
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        @(negedge sys_clk);
        t_reset();
        t_fast_wheel();
        t_central();
        t_master();
        t_routed();
        t_watch();
        test_done();
    end
endmodule // clock_timewheel_and_dividers_tb

`default_nettype wire
